// ===== design/fkch_defines.vh
/*
 * constants of the form keypad and cursor handler: register map, control bits,
 * key codes from the keyboard scanner, codes sent to the host, timing.
 * assumes a 100 MHz system clock and a 7-bit key code from the scanner.
 */
`ifndef FKCH_DEFINES_VH
`define FKCH_DEFINES_VH

`define FKCH_CLK_KHZ        100000
`define FKCH_SHORT_TEST_MS  10000
`define FKCH_REPEAT_MS      50
`define FKCH_SETTLE         3'd4

`define FKCH_ADDR_W         12
`define FKCH_OFF_CTRL       12'h000
`define FKCH_OFF_GEOM       12'h004
`define FKCH_OFF_STATUS     12'h008
`define FKCH_OFF_SELECT     12'h00c
`define FKCH_OFF_LASTCODE   12'h010

`define FKCH_CTRL_FN        0
`define FKCH_CTRL_AUTOTAB   1
`define FKCH_CTRL_MENU      2
`define FKCH_CTRL_INSERT    3
`define FKCH_CTRL_LOCK      4
`define FKCH_CTRL_RAISE     5
`define FKCH_CTRL_RST       5'h00
`define FKCH_GEOM_LAST_LO   0
`define FKCH_GEOM_DISP_LO   8
`define FKCH_LAST_RST       4'hf
`define FKCH_DISP_RST       4'h8

`define FKCH_K_RIGHT        7'h01
`define FKCH_K_LEFT         7'h02
`define FKCH_K_FWD          7'h03
`define FKCH_K_BACK         7'h04
`define FKCH_K_SELECT       7'h05
`define FKCH_K_NEXT         7'h06
`define FKCH_K_ERASE        7'h07
`define FKCH_K_REMOVE       7'h08
`define FKCH_K_ERRRST       7'h09
`define FKCH_K_PERIOD       7'h2e
`define FKCH_K_DIG0         7'h30
`define FKCH_K_DIG9         7'h39
`define FKCH_K_PRINT_LO     7'h20
`define FKCH_K_PRINT_HI     7'h7e

`define FKCH_C_ESC          8'h1b
`define FKCH_C_PF_BASE      8'h50
`define FKCH_C_ABORT        8'h18
`define FKCH_PF_ABORT_IDX   4'h7
`define FKCH_PF_PERIOD_IDX  4'ha

`define FKCH_OP_CLR_END     2'h0
`define FKCH_OP_ERASE       2'h1
`define FKCH_OP_REMOVE      2'h2

`endif

// ===== design/fkch_sync.v
/*
 * three-stage synchroniser for a bus of pin levels.
 * the output bit changes only once the second and third stages agree;
 * assumes each bit is an independent slow level (keys, modem lines).
 */
`timescale 1ns/1ps

module fkch_sync #(
  parameter W = 1
) (
  input  wire         mclk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
    end
  end

endmodule

// ===== design/fkch_top.v
/*
 * form keypad and cursor handler: key events, repeat, keypad modes, cursor
 * moves between form fields, menu selection, error mode, lamps, self-test,
 * apb register slave.
 * assumes debounced key levels from the scanner, field checking done outside
 * (check_fail_i answers a check_stb_o), link status from the protocol logic.
 */
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "fkch_defines.vh"

module fkch_top #(
  parameter [31:0] SHORT_CYCLES = `FKCH_SHORT_TEST_MS * `FKCH_CLK_KHZ,
  parameter [31:0] REP_CYCLES   = `FKCH_REPEAT_MS * `FKCH_CLK_KHZ,
  parameter        NFIELD       = 16
) (
  input  wire                   mclk_i,
  input  wire                   rst_i,
  input  wire                   psel_i,
  input  wire                   penable_i,
  input  wire                   pwrite_i,
  input  wire [`FKCH_ADDR_W-1:0] paddr_i,
  input  wire [31:0]            pwdata_i,
  output reg  [31:0]            prdata_o,
  output wire                   pready_o,
  output wire                   pslverr_o,
  input  wire [6:0]             key_code_i,
  input  wire                   key_down_i,
  input  wire                   shift_i,
  input  wire                   repeat_key_i,
  input  wire                   capitals_latch_key_i,
  input  wire                   carrier_i,
  input  wire                   clear_to_send_i,
  input  wire                   link_ready_i,
  input  wire                   check_fail_i,
  output reg  [7:0]             code_o,
  output reg                    code_stb_o,
  output reg                    check_stb_o,
  output reg  [3:0]             check_field_o,
  output reg                    edit_stb_o,
  output reg  [1:0]             edit_op_o,
  output reg                    bell_o,
  output reg  [3:0]             cur_field_o,
  output reg  [3:0]             cur_pos_o,
  output wire                   ready_lamp_o,
  output wire                   input_locked_lamp_o,
  output wire                   function_keypad_lamp_o,
  output wire                   insert_lamp_o,
  output wire                   display_area_lamp_o,
  output wire                   clear_to_send_lamp_o,
  output wire                   carrier_lamp_o,
  output wire                   entry_error_lamp_o
);

  localparam [3:0] ST_INIT  = 4'b0001;
  localparam [3:0] ST_LONG  = 4'b0010;
  localparam [3:0] ST_SHORT = 4'b0100;
  localparam [3:0] ST_RUN   = 4'b1000;
  localparam [3:0] POS_LAST = 4'hf;

  wire [12:0] kin_q;
  wire [6:0]  kc       = kin_q[6:0];
  wire        kdown    = kin_q[7];
  wire        kshift   = kin_q[8];
  wire        krepeat  = kin_q[9];
  wire        kcaps    = kin_q[10];
  wire        carrier  = kin_q[11];
  wire        cts      = kin_q[12];

  fkch_sync #(.W(13)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({clear_to_send_i, carrier_i, capitals_latch_key_i, repeat_key_i,
              shift_i, key_down_i, key_code_i}),
    .q_o    (kin_q)
  );

  // key classes, used by the repeat logic and the action decoder
  function is_digit;
    input [6:0] c;
    is_digit = (c >= `FKCH_K_DIG0 && c <= `FKCH_K_DIG9) || c == `FKCH_K_PERIOD;
  endfunction

  function is_print;
    input [6:0] c;
    is_print = c >= `FKCH_K_PRINT_LO && c <= `FKCH_K_PRINT_HI;
  endfunction

  function is_auto_rep;
    input [6:0] c;
    is_auto_rep = c == `FKCH_K_NEXT || c == `FKCH_K_ERASE || c == `FKCH_K_REMOVE ||
                  c == `FKCH_K_LEFT || c == `FKCH_K_RIGHT || c == `FKCH_K_FWD ||
                  c == `FKCH_K_BACK;
  endfunction

  reg [3:0]  st_r;
  reg [3:0]  st_nxt;
  reg [2:0]  settle_r;
  reg [31:0] test_cnt_r;
  reg        caps_d_r;
  reg        kdown_d_r;
  reg [31:0] rep_cnt_r;
  reg [4:0]  ctrl_r;
  reg [3:0]  last_field_r;
  reg [3:0]  disp_first_r;
  reg [NFIELD-1:0] sel_r;
  reg [NFIELD-1:0] sel_nxt;
  reg [3:0]  field_r;
  reg [3:0]  field_nxt;
  reg [3:0]  pos_r;
  reg [3:0]  pos_nxt;
  reg        past_r;
  reg        past_nxt;
  reg        error_r;
  reg [7:0]  seq2_r;
  reg        seq2_v_r;
  reg [7:0]  last_code_r;

  reg        send1;
  reg        send2;
  reg [7:0]  byte1;
  reg [7:0]  byte2;
  reg        chk;
  reg [3:0]  chk_field;
  reg        edit;
  reg [1:0]  op;
  reg        bell;
  reg        err_clr;
  reg [3:0]  pf_idx;

  wire running  = st_r == ST_RUN;
  wire locked   = ctrl_r[`FKCH_CTRL_LOCK] | ~running;
  wire in_disp  = field_r >= disp_first_r;
  wire fn_mode  = ctrl_r[`FKCH_CTRL_FN];

  wire apb_wr   = psel_i & penable_i & pwrite_i;
  wire apb_setup = psel_i & ~penable_i;
  wire hit      = paddr_i == `FKCH_OFF_CTRL || paddr_i == `FKCH_OFF_GEOM ||
                  paddr_i == `FKCH_OFF_STATUS || paddr_i == `FKCH_OFF_SELECT ||
                  paddr_i == `FKCH_OFF_LASTCODE;
  wire raise    = apb_wr && paddr_i == `FKCH_OFF_CTRL && pwdata_i[`FKCH_CTRL_RAISE];

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  wire press    = kdown & ~kdown_d_r;
  wire rep_ok   = is_auto_rep(kc) | (krepeat & (is_print(kc) | is_digit(kc)));
  wire rep_fire = kdown & kdown_d_r & rep_ok && rep_cnt_r == REP_CYCLES - 32'h1;
  wire key_evt  = running & (press | rep_fire);

  always @(posedge mclk_i) begin
    if (rst_i) begin
      kdown_d_r <= 1'b0;
      rep_cnt_r <= 32'h0;
    end else begin
      kdown_d_r <= kdown;
      if (!kdown || press || rep_fire)
        rep_cnt_r <= 32'h0;
      else
        rep_cnt_r <= rep_cnt_r + 32'h1;
    end
  end

  // self-test sequencer
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_INIT: begin
        // caps level caught after sync settles
        if (settle_r == `FKCH_SETTLE)
          st_nxt = kcaps ? ST_SHORT : ST_LONG;
      end
      ST_LONG: begin
        if (kcaps & ~caps_d_r)
          st_nxt = ST_SHORT;
      end
      ST_SHORT: begin
        if (test_cnt_r == SHORT_CYCLES - 32'h1)
          st_nxt = ST_RUN;
      end
      ST_RUN: st_nxt = ST_RUN;
      default: st_nxt = ST_INIT;
    endcase
  end

  // key action decoder
  always @* begin
    field_nxt = field_r;
    pos_nxt   = pos_r;
    past_nxt  = past_r;
    sel_nxt   = sel_r;
    send1     = 1'b0;
    send2     = 1'b0;
    byte1     = {1'b0, kc};
    byte2     = 8'h00;
    chk       = 1'b0;
    chk_field = field_r;
    edit      = 1'b0;
    op        = `FKCH_OP_CLR_END;
    bell      = 1'b0;
    err_clr   = 1'b0;
    pf_idx    = (kc == `FKCH_K_PERIOD) ? `FKCH_PF_PERIOD_IDX : kc[3:0];
    if (key_evt) begin
      // error mode rings the bell for any key but error reset, which clears it
      if (error_r) begin
        if (kc == `FKCH_K_ERRRST)
          err_clr = 1'b1;
        else
          bell = 1'b1;
      end else if (is_digit(kc)) begin
        if (!locked && (fn_mode || kshift)) begin
          if (pf_idx == `FKCH_PF_ABORT_IDX) begin
            send1 = 1'b1;
            byte1 = `FKCH_C_ABORT;
          end else begin
            send1 = 1'b1;
            send2 = 1'b1;
            byte1 = `FKCH_C_ESC;
            byte2 = `FKCH_C_PF_BASE + {4'h0, pf_idx};
          end
        end else if (!locked && !past_r) begin
          send1 = 1'b1;
          if (pos_r != POS_LAST)
            pos_nxt = pos_r + 4'h1;
        end
      end else if (is_print(kc)) begin
        if (!locked && !past_r) begin
          send1 = 1'b1;
          if (pos_r != POS_LAST)
            pos_nxt = pos_r + 4'h1;
        end
      end else begin
        case (kc)
          `FKCH_K_RIGHT: begin
            if (pos_r != POS_LAST) begin
              pos_nxt  = pos_r + 4'h1;
              past_nxt = 1'b0;
            end else if (ctrl_r[`FKCH_CTRL_AUTOTAB] && field_r != last_field_r) begin
              field_nxt = field_r + 4'h1;
              pos_nxt   = 4'h0;
              past_nxt  = 1'b0;
              chk       = 1'b1;
            end
          end
          `FKCH_K_LEFT: begin
            if (pos_r != 4'h0) begin
              pos_nxt  = pos_r - 4'h1;
              past_nxt = 1'b0;
            end
          end
          `FKCH_K_FWD: begin
            chk = 1'b1;
            if (field_r == last_field_r) begin
              pos_nxt  = POS_LAST;
              past_nxt = 1'b1;
            end else begin
              field_nxt = field_r + 4'h1;
              pos_nxt   = 4'h0;
              past_nxt  = 1'b0;
            end
          end
          `FKCH_K_BACK: begin
            if (pos_r == 4'h0 && field_r != 4'h0)
              field_nxt = field_r - 4'h1;
            pos_nxt  = 4'h0;
            past_nxt = 1'b0;
          end
          `FKCH_K_NEXT: begin
            chk  = 1'b1;
            edit = 1'b1;
            op   = `FKCH_OP_CLR_END;
            if (field_r != last_field_r) begin
              field_nxt = field_r + 4'h1;
              pos_nxt   = 4'h0;
              past_nxt  = 1'b0;
            end
          end
          `FKCH_K_ERASE: begin
            edit = !past_r;
            op   = `FKCH_OP_ERASE;
            if (!past_r && pos_r != 4'h0)
              pos_nxt = pos_r - 4'h1;
          end
          `FKCH_K_REMOVE: begin
            edit = !past_r;
            op   = `FKCH_OP_REMOVE;
          end
          `FKCH_K_SELECT: begin
            if (ctrl_r[`FKCH_CTRL_MENU] && in_disp && !locked)
              sel_nxt[field_r] = ~kshift;
          end
          default: bell = 1'b0;
        endcase
      end
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      st_r          <= ST_INIT;
      settle_r      <= 3'h0;
      test_cnt_r    <= 32'h0;
      caps_d_r      <= 1'b0;
      ctrl_r        <= `FKCH_CTRL_RST;
      last_field_r  <= `FKCH_LAST_RST;
      disp_first_r  <= `FKCH_DISP_RST;
      sel_r         <= {NFIELD{1'b0}};
      field_r       <= 4'h0;
      pos_r         <= 4'h0;
      past_r        <= 1'b0;
      error_r       <= 1'b0;
      seq2_r        <= 8'h00;
      seq2_v_r      <= 1'b0;
      last_code_r   <= 8'h00;
      code_o        <= 8'h00;
      code_stb_o    <= 1'b0;
      check_stb_o   <= 1'b0;
      check_field_o <= 4'h0;
      edit_stb_o    <= 1'b0;
      edit_op_o     <= `FKCH_OP_CLR_END;
      bell_o        <= 1'b0;
      prdata_o      <= 32'h0;
    end else begin
      st_r     <= st_nxt;
      caps_d_r <= kcaps;
      if (st_r == ST_INIT && settle_r != `FKCH_SETTLE)
        settle_r <= settle_r + 3'h1;
      test_cnt_r <= (st_r == ST_SHORT) ? test_cnt_r + 32'h1 : 32'h0;
      if (st_r == ST_SHORT && st_nxt == ST_RUN) begin
        // home cursor at end of test
        field_r <= 4'h0;
        pos_r   <= 4'h0;
        past_r  <= 1'b0;
      end else begin
        field_r <= field_nxt;
        pos_r   <= pos_nxt;
        past_r  <= past_nxt;
      end
      sel_r <= sel_nxt;
      // set wins over error reset
      error_r <= check_fail_i | raise | (error_r & ~err_clr);
      // codes go out per key event
      if (send1) begin
        code_o      <= byte1;
        code_stb_o  <= 1'b1;
        last_code_r <= byte1;
        seq2_v_r    <= send2;
        seq2_r      <= byte2;
      end else if (seq2_v_r) begin
        code_o      <= seq2_r;
        code_stb_o  <= 1'b1;
        last_code_r <= seq2_r;
        seq2_v_r    <= 1'b0;
      end else begin
        code_stb_o <= 1'b0;
      end
      check_stb_o <= chk;
      if (chk)
        check_field_o <= chk_field;
      edit_stb_o <= edit;
      if (edit)
        edit_op_o <= op;
      bell_o <= bell;
      if (apb_wr && paddr_i == `FKCH_OFF_CTRL)
        ctrl_r <= pwdata_i[4:0];
      if (apb_wr && paddr_i == `FKCH_OFF_GEOM) begin
        last_field_r <= pwdata_i[`FKCH_GEOM_LAST_LO +: 4];
        disp_first_r <= pwdata_i[`FKCH_GEOM_DISP_LO +: 4];
      end
      if (apb_setup) begin
        case (paddr_i)
          `FKCH_OFF_CTRL:     prdata_o <= {27'h0, ctrl_r};
          `FKCH_OFF_GEOM:     prdata_o <= {20'h0, disp_first_r, 4'h0, last_field_r};
          `FKCH_OFF_STATUS:   prdata_o <= {9'h0, in_disp, st_r, locked, error_r,
                                           past_r, 3'h0, pos_r, 4'h0, field_r};
          `FKCH_OFF_SELECT:   prdata_o <= {{(32-NFIELD){1'b0}}, sel_r};
          `FKCH_OFF_LASTCODE: prdata_o <= {24'h0, last_code_r};
          default:            prdata_o <= 32'h0;
        endcase
      end
    end
  end

  always @* begin
    cur_field_o = field_r;
    cur_pos_o   = pos_r;
  end

  assign ready_lamp_o           = link_ready_i;
  // locked during test or by host
  assign input_locked_lamp_o    = locked;
  assign function_keypad_lamp_o = fn_mode;
  assign insert_lamp_o          = ctrl_r[`FKCH_CTRL_INSERT];
  assign display_area_lamp_o    = in_disp;
  assign clear_to_send_lamp_o   = cts;
  assign carrier_lamp_o         = carrier;
  assign entry_error_lamp_o     = error_r;

endmodule

// ===== tb/fkch_checker.sv
/* assertion checker of the keypad and cursor handler, bound to fkch_top.
   assumes one clock mclk_i and the synchronous reset rst_i. */
`timescale 1ns/1ps
module fkch_checker (
  input logic       mclk_i, rst_i, psel_i, penable_i, pwrite_i,
  input logic       carrier_i, clear_to_send_i, link_ready_i,
  input logic [7:0] code_o,
  input logic       code_stb_o, check_stb_o, bell_o,
  input logic [3:0] cur_field_o, cur_pos_o,
  input logic       ready_lamp_o, input_locked_lamp_o, clear_to_send_lamp_o,
  input logic       carrier_lamp_o, entry_error_lamp_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  ready_lamp_a: assert property (ready_lamp_o == link_ready_i)
    else $error("ready lamp differs from link level");
  carrier_lamp_a: assert property ($rose(carrier_i) |-> ##[1:6] carrier_lamp_o)
    else $error("carrier lamp did not light");
  cts_lamp_a: assert property ($fell(clear_to_send_i) |-> ##[1:6] !clear_to_send_lamp_o)
    else $error("clear to send lamp did not go out");
  selftest_first_a: assert property ($fell(rst_i) |-> input_locked_lamp_o [*8])
    else $error("keyboard enabled right after reset");
  home_on_run_a: assert property ($fell(input_locked_lamp_o)
      && !$past(psel_i && penable_i && pwrite_i) |-> cur_field_o == 4'h0 && cur_pos_o == 4'h0)
    else $error("cursor not home when keyboard enabled");
  error_quiet_a: assert property (entry_error_lamp_o && $past(entry_error_lamp_o, 3)
      |-> !code_stb_o && !check_stb_o)
    else $error("key acted while in error");
  bell_error_a: assert property (bell_o |-> entry_error_lamp_o || $past(entry_error_lamp_o))
    else $error("bell outside error mode");
  lock_quiet_a: assert property (input_locked_lamp_o && $past(input_locked_lamp_o, 3)
      |-> !code_stb_o)
    else $error("code sent while input_locked_lamp");
  pf_pair_a: assert property (code_stb_o && code_o == 8'h1b
      |=> code_stb_o && code_o[7:4] == 4'h5)
    else $error("function code sequence broken");
endmodule

bind fkch_top fkch_checker u_fkch_checker (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .carrier_i, .clear_to_send_i, .link_ready_i, .code_o, .code_stb_o, .check_stb_o, .bell_o,
  .cur_field_o, .cur_pos_o, .ready_lamp_o, .input_locked_lamp_o, .clear_to_send_lamp_o,
  .carrier_lamp_o, .entry_error_lamp_o);

// ===== tb/fkch_kbd_model.sv
/* behavioural operator keyboard, field checker and link levels.
   assumes press() is called just after a rising clock edge. */
`timescale 1ns/1ps
module fkch_kbd_model (
  input  wire        mclk_i,
  input  wire        check_stb_i,
  output logic [6:0] key_code_o   = 7'h7f,
  output logic       key_down_o   = 1'b0,
  output logic       shift_o      = 1'b0,
  output logic       repeat_key_o = 1'b0,
  output logic       caps_o       = 1'b0,
  output logic       carrier_o    = 1'b0,
  output logic       cts_o        = 1'b0,
  output logic       link_ready_o = 1'b0,
  output logic       check_fail_o = 1'b0
);
  logic fail_next = 1'b0;

  task automatic press(input logic [6:0] k, input logic s, input int h);
    key_code_o <= k;
    shift_o <= s;
    @(posedge mclk_i);
    key_down_o <= 1'b1;
    repeat (h) @(posedge mclk_i);
    key_down_o <= 1'b0;
    @(posedge mclk_i);
    key_code_o <= ~k;
    shift_o <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask

  always @(posedge mclk_i) begin
    check_fail_o <= check_stb_i & fail_next;
    if (check_stb_i) fail_next <= 1'b0;
  end
endmodule

// ===== tb/test_form_keypad_cursor_handler.sv
/* self-checking bench of the keypad and cursor handler over apb and keys.
   assumes fkch_top with shortened self-test and repeat counts. */
`timescale 1ns/1ps
`include "fkch_defines.vh"
module test_form_keypad_cursor_handler;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, er;
  logic [11:0] pa = 0;
  logic [31:0] pw = 0, prd, rd;
  logic        prdy, perr, kd, sh, rk, cl, car, cts, lrdy, fail, cstb, fchk, est, bell;
  logic [6:0]  kc, k;
  logic [7:0]  code;
  wire  [7:0]  lamp;
  logic [3:0]  cf, cfld, cpos, lcf;
  logic [1:0]  eop, leop;
  logic [7:0]  q[$];
  int          errors = 0, num_checks = 0, cyc = 0, nbell = 0, nchk = 0, t0;

  fkch_top #(.SHORT_CYCLES(32'd50), .REP_CYCLES(32'd20)) DUT (
    .mclk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pw), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .key_code_i(kc), .key_down_i(kd), .shift_i(sh), .repeat_key_i(rk),
    .capitals_latch_key_i(cl), .carrier_i(car), .clear_to_send_i(cts),
    .link_ready_i(lrdy), .check_fail_i(fail), .code_o(code), .code_stb_o(cstb),
    .check_stb_o(fchk), .check_field_o(cf), .edit_stb_o(est), .edit_op_o(eop),
    .bell_o(bell), .cur_field_o(cfld), .cur_pos_o(cpos), .ready_lamp_o(lamp[0]),
    .input_locked_lamp_o(lamp[1]), .function_keypad_lamp_o(lamp[2]),
    .insert_lamp_o(lamp[3]), .display_area_lamp_o(lamp[4]),
    .clear_to_send_lamp_o(lamp[5]), .carrier_lamp_o(lamp[6]), .entry_error_lamp_o(lamp[7]));

  fkch_kbd_model kb (.mclk_i(clk), .check_stb_i(fchk), .key_code_o(kc), .key_down_o(kd),
    .shift_o(sh), .repeat_key_o(rk), .caps_o(cl), .carrier_o(car), .cts_o(cts),
    .link_ready_o(lrdy), .check_fail_o(fail));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // monitor of codes, checks and bells; cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cstb === 1'b1) q.push_back(code);
    if (fchk === 1'b1) begin
      nchk++;
      lcf = cf;
    end
    if (bell === 1'b1) nbell++;
    if (est === 1'b1) leop = eop;
    if (cyc > 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask

  task automatic cur(input string nm, input logic [3:0] f, input logic [3:0] p);
    chk(nm, {f, p}, {cfld, cpos});
  endtask

  task automatic keyq(input logic [6:0] kk, input logic s, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
    q.delete();
    kb.press(kk, s, 3);
    chk("code count", n, q.size());
    if (n > 0) chk("first code", e0, q[0]);
    if (n > 1) chk("second code", e1, q[1]);
  endtask

  task automatic pfk(input logic [6:0] kk, input int i, input logic s);
    if (i == 7) keyq(kk, s, 1, `FKCH_C_ABORT, 8'h00);
    else keyq(kk, s, 2, `FKCH_C_ESC, `FKCH_C_PF_BASE + i[7:0]);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rdc("ctrl reset", `FKCH_OFF_CTRL, 32'h3f, 32'h0);
    rdc("geom reset", `FKCH_OFF_GEOM, 32'hf0f, 32'h80f);
    apb(0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    repeat (10) @(posedge clk);
    rdc("long test", `FKCH_OFF_STATUS, 32'h3c0000, 32'h080000);
    chk("locked in test", 1, lamp[1]);
    t0 = cyc;
    kb.caps_o <= 1'b1;
    for (int i = 0; i < 300 && lamp[1] !== 1'b0; i++) @(posedge clk);
    chk("short test span", 1, (cyc - t0) >= 50 && (cyc - t0) <= 70);
    rdc("run state", `FKCH_OFF_STATUS, 32'h3c0000, 32'h200000);
    cur("home", 0, 0);
    kb.press(`FKCH_K_LEFT, 0, 3);
    cur("left at start", 0, 0);
    kb.press(`FKCH_K_RIGHT, 0, 3);
    cur("right", 0, 1);
    kb.press(`FKCH_K_RIGHT, 0, 400);
    cur("right held", 0, 15);
    kb.press(`FKCH_K_LEFT, 0, 3);
    cur("left", 0, 14);
    apb(1, `FKCH_OFF_CTRL, 32'h2);
    rdc("ctrl rw", `FKCH_OFF_CTRL, 32'h3f, 32'h2);
    kb.press(`FKCH_K_RIGHT, 0, 3);
    nchk = 0;
    kb.press(`FKCH_K_RIGHT, 0, 3);
    cur("auto tab", 1, 0);
    chk("auto tab check", 32'h10, {nchk[3:0], lcf});
    kb.press(`FKCH_K_RIGHT, 0, 3);
    nchk = 0;
    kb.press(`FKCH_K_FWD, 0, 3);
    cur("forward", 2, 0);
    chk("forward check", 32'h11, {nchk[3:0], lcf});
    kb.press(`FKCH_K_BACK, 0, 3);
    cur("back at start", 1, 0);
    kb.press(`FKCH_K_RIGHT, 0, 3);
    kb.press(`FKCH_K_BACK, 0, 3);
    cur("back mid", 1, 0);
    apb(1, `FKCH_OFF_GEOM, 32'h101);
    nchk = 0;
    kb.press(`FKCH_K_FWD, 0, 3);
    cur("forward last", 1, 15);
    rdc("past end", `FKCH_OFF_STATUS, 32'h8000, 32'h8000);
    chk("last check", 32'h11, {nchk[3:0], lcf});
    keyq(7'h35, 0, 0, 8'h00, 8'h00);
    chk("display lamp", 1, lamp[4]);
    kb.press(`FKCH_K_BACK, 0, 3);
    apb(1, `FKCH_OFF_CTRL, 32'h4);
    kb.press(`FKCH_K_SELECT, 0, 3);
    rdc("select", `FKCH_OFF_SELECT, 32'h2, 32'h2);
    kb.press(`FKCH_K_SELECT, 1, 3);
    rdc("deselect", `FKCH_OFF_SELECT, 32'h2, 32'h0);
    apb(1, `FKCH_OFF_CTRL, 32'h0);
    for (int i = 0; i < 11; i++) begin
      k = (i == 10) ? `FKCH_K_PERIOD : `FKCH_K_DIG0 + i[6:0];
      keyq(k, 0, 1, {1'b0, k}, 8'h00);
      pfk(k, i, 1);
    end
    apb(1, `FKCH_OFF_CTRL, 32'h1);
    chk("function lamp", 1, lamp[2]);
    for (int i = 0; i < 11; i++) begin
      k = (i == 10) ? `FKCH_K_PERIOD : `FKCH_K_DIG0 + i[6:0];
      pfk(k, i, 0);
      pfk(k, i, 1);
    end
    apb(1, `FKCH_OFF_CTRL, 32'h0);
    q.delete();
    kb.press(7'h35, 0, 80);
    chk("held once", 1, q.size());
    q.delete();
    kb.repeat_key_o <= 1'b1;
    repeat (80) @(posedge clk);
    chk("repeat alone", 0, q.size());
    kb.press(7'h33, 1, 80);
    chk("sequence repeats", 1, q.size() >= 4 && q.size() % 2 == 0);
    foreach (q[j]) chk("sequence code", (j % 2) ? 8'h53 : 8'h1b, q[j]);
    q.delete();
    kb.press(7'h41, 0, 80);
    chk("printable repeats", 1, q.size() >= 3);
    rdc("last code", `FKCH_OFF_LASTCODE, 32'hff, 32'h41);
    kb.repeat_key_o <= 1'b0;
    apb(1, `FKCH_OFF_CTRL, 32'h10);
    keyq(7'h35, 0, 0, 8'h00, 8'h00);
    kb.press(`FKCH_K_LEFT, 0, 3);
    cur("locked cursor", 1, 14);
    apb(1, `FKCH_OFF_CTRL, 32'h8);
    kb.carrier_o <= 1'b1;
    kb.cts_o <= 1'b1;
    kb.link_ready_o <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lamps on", 8'h79, lamp);
    kb.carrier_o <= 1'b0;
    kb.cts_o <= 1'b0;
    kb.link_ready_o <= 1'b0;
    apb(1, `FKCH_OFF_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    chk("lamps off", 8'h10, lamp);
    kb.press(`FKCH_K_ERASE, 0, 80);
    cur("erase held", 1, 10);
    chk("erase op", `FKCH_OP_ERASE, leop);
    kb.press(`FKCH_K_REMOVE, 0, 3);
    chk("remove op", `FKCH_OP_REMOVE, leop);
    nchk = 0;
    kb.press(`FKCH_K_NEXT, 0, 3);
    chk("next op", {`FKCH_OP_CLR_END, 4'h1}, {leop, nchk[3:0]});
    kb.fail_next <= 1'b1;
    kb.press(`FKCH_K_FWD, 0, 3);
    chk("error lamp", 1, lamp[7]);
    nbell = 0;
    kb.press(`FKCH_K_LEFT, 0, 3);
    cur("error frozen", 1, 15);
    chk("error bell", 1, nbell);
    kb.press(`FKCH_K_ERRRST, 0, 3);
    rdc("error cleared", `FKCH_OFF_STATUS, 32'h10000, 32'h0);
    wrap_up();
  end
endmodule
